// >>> core/raec_pkg.sv
package raec_pkg;
    // Sample cadence: one datapath step every four master clocks
    localparam int unsigned SMP_DIV = 4;
    localparam int unsigned SMP_CNT_W = 2;
    // Apparent energy accumulator and register widths
    localparam int unsigned ACC_W = 48;
    localparam int unsigned EREG_W = 24;
    localparam int unsigned EREG_LSB = ACC_W - EREG_W;
    // Gain trim: signed 12-bit, scaled by 2^12
    localparam int unsigned GAIN_W = 12;
    localparam int unsigned GAIN_SH = 12;
    localparam int unsigned DIV_W = 8;
    localparam int unsigned HCYC_W = 16;
    // Status bit positions and reset values
    localparam int unsigned ST_CYC_END = 0;
    localparam int unsigned ST_VA_HALF = 1;
    localparam int unsigned ST_VA_OVF = 2;
    localparam int unsigned ST_W = 3;
    localparam logic [ST_W-1:0] ST_RESET = 3'h0;
    // Filter shifts: leaky integrator for the quarter-cycle shift, power low-pass
    localparam int unsigned PS_LEAK_SH = 6;
    localparam int unsigned LPF_SH = 8;

    typedef struct packed {
        logic line_accumulation_select;
        logic integrator_en;
        logic [HCYC_W-1:0] half_cycle_count;
        logic [GAIN_W-1:0] apparent_gain;
        logic [DIV_W-1:0] apparent_divisor;
        logic [ST_W-1:0] irq_mask;
    } raec_cfg_s;

    typedef enum logic [1:0] {
        LC_IDLE = 2'h0,
        LC_ARM = 2'h1,
        LC_RUN = 2'h3
    } raec_lc_e;
endpackage

// >>> core/raec_core.sv
`timescale 1ns/1ps
// Behaviour
// - Reactive product is quarter-cycle shifted current times voltage, every sample.
// - Reactive product is low-pass filtered; the dc level is reactive power.
// - Reactive power accumulates over the programmed 16-bit count of half cycles.
// - Completion of a line accumulation period sets the cycle-end status flag.
// - Unmasked cycle-end flag drives the interrupt output active low.
// - Shift is minus a quarter cycle with integrator on, plus with it off.
// - Reactive power is signed; for a given phase angle its sign flips between the two modes.
// - Apparent power is current rms times voltage rms.
// - Apparent power scaled by one plus signed 12-bit gain over 4096.
// - No separate offset term in the apparent power path.
// - Every apparent power sample is added into a 48-bit accumulator.
// - Apparent energy accumulation uses signed addition.
// - Energy accumulators update once every four master clocks.
// - Apparent energy divided by unsigned 8-bit divisor; zero acts as one.
// - Upper 24 bits of the quotient form the apparent energy register.
// - A read-to-clear 24-bit apparent energy copy returns to zero after reads.
// - Enabled half-full and overflow events of the apparent register interrupt.
// - Half-full is judged on the full unsigned 24-bit range.
// - Line accumulation periods start and end on voltage zero crossings.
// - Mode select bit starts line accumulation and repeats periods while set.
module raec_core #(
    parameter int unsigned SW = 16,
    parameter int unsigned RW = 24,
    parameter int unsigned QW = 48
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Channel samples and rms values from upstream logic
    input wire logic signed [SW-1:0] cur_sample,
    input wire logic signed [SW-1:0] volt_sample,
    input wire logic [RW-1:0] cur_rms,
    input wire logic [RW-1:0] volt_rms,
    input wire logic volt_zero_cross,
    // Configuration registers
    input wire raec_pkg::raec_cfg_s cfg,
    // Register read strobes
    input wire logic read_clear_rd,
    input wire logic status_rd,
    // Results
    output logic signed [2*SW-1:0] reactive_power,
    output logic signed [QW-1:0] line_reactive_energy,
    output logic [raec_pkg::EREG_W-1:0] apparent_energy_value,
    output logic [raec_pkg::EREG_W-1:0] apparent_energy_read_clear,
    output logic [raec_pkg::ST_W-1:0] irq_status,
    // Open-drain interrupt pin
    output logic irq_pin_out,
    output logic irq_pin_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Sample enable divider
    logic [raec_pkg::SMP_CNT_W-1:0] div_q;
    logic smp_en;

    // One pulse every SMP_DIV clocks drives every accumulator
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (div_q == raec_pkg::SMP_CNT_W'(raec_pkg::SMP_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign smp_en = (div_q == raec_pkg::SMP_CNT_W'(raec_pkg::SMP_DIV - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Quarter-cycle phase shift and reactive power
    localparam int unsigned IW = SW + raec_pkg::PS_LEAK_SH;
    localparam int unsigned PW = 2 * SW;
    logic signed [IW-1:0] integ_q;
    logic signed [SW-1:0] cur_shift;
    logic signed [PW-1:0] react_inst;
    logic signed [PW-1:0] lpf_q;

    // Leaky integrator lags the current by close to 90 degrees above its corner
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            integ_q <= '0;
        end else if (smp_en) begin
            integ_q <= integ_q + IW'(cur_sample) - (integ_q >>> raec_pkg::PS_LEAK_SH);
        end
    end

    // Integrator on: lagging form; off: negated, which leads by 90 degrees
    always_comb begin
        cur_shift = integ_q[IW-1 -: SW];
        if (!cfg.integrator_en) begin
            cur_shift = -integ_q[IW-1 -: SW];
        end
    end

    // Full-width signed product, no rounding ahead of the filter
    assign react_inst = cur_shift * volt_sample;

    // First-order low-pass keeps only the dc part of the product
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lpf_q <= '0;
        end else if (smp_en) begin
            lpf_q <= lpf_q + ((react_inst - lpf_q) >>> raec_pkg::LPF_SH);
        end
    end
    assign reactive_power = lpf_q;

    ////////////////////////////////////////////////////////////////////////////
    // Line cycle reactive accumulation
    raec_pkg::raec_lc_e lc_q;
    logic [raec_pkg::HCYC_W-1:0] hc_q;
    logic signed [QW-1:0] lacc_q;
    logic period_done;

    // A count of zero behaves as one: the first counted crossing closes the period
    assign period_done = (lc_q == raec_pkg::LC_RUN) && volt_zero_cross && (hc_q + 1'b1 >= cfg.half_cycle_count);

    // Arm on select, open period on a zero crossing, close on the last crossing
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lc_q <= raec_pkg::LC_IDLE;
        end else begin
            case (lc_q)
                raec_pkg::LC_IDLE: begin
                    if (cfg.line_accumulation_select) begin
                        lc_q <= raec_pkg::LC_ARM;
                    end
                end
                raec_pkg::LC_ARM: begin
                    if (!cfg.line_accumulation_select) begin
                        lc_q <= raec_pkg::LC_IDLE;
                    end else if (volt_zero_cross) begin
                        lc_q <= raec_pkg::LC_RUN;
                    end
                end
                raec_pkg::LC_RUN: begin
                    // Next period starts at the same crossing while select stays set
                    if (period_done && !cfg.line_accumulation_select) begin
                        lc_q <= raec_pkg::LC_IDLE;
                    end
                end
                default: begin
                    lc_q <= raec_pkg::LC_IDLE;
                end
            endcase
        end
    end

    // Half-cycle counter counts crossings inside a period
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hc_q <= '0;
        end else if (lc_q != raec_pkg::LC_RUN || period_done) begin
            hc_q <= '0;
        end else if (volt_zero_cross) begin
            hc_q <= hc_q + 1'b1;
        end
    end

    // Running sum restarts at each period boundary
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lacc_q <= '0;
        end else if (lc_q != raec_pkg::LC_RUN || period_done) begin
            lacc_q <= '0;
        end else if (smp_en) begin
            lacc_q <= lacc_q + QW'(lpf_q);
        end
    end

    // Result register holds the last completed period
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_reactive_energy <= '0;
        end else if (period_done) begin
            line_reactive_energy <= lacc_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Apparent power with gain trim
    localparam int unsigned VW = 2 * RW;
    localparam int unsigned GW = VW + raec_pkg::GAIN_W + 1;
    logic [VW-1:0] va_raw;
    logic signed [GW-1:0] va_ext;
    logic signed [GW-1:0] va_trim;
    logic signed [raec_pkg::ACC_W-1:0] va_sample;

    // Product of rms values only; offsets are trimmed in the rms blocks
    assign va_raw = cur_rms * volt_rms;
    assign va_ext = GW'({1'b0, va_raw});
    // Multiply then shift keeps the 1/4096 step exact before truncation
    assign va_trim = va_ext + ((va_ext * GW'(signed'(cfg.apparent_gain))) >>> raec_pkg::GAIN_SH);
    // Keep the upper rms-width bits as the power word fed to the accumulator
    assign va_sample = raec_pkg::ACC_W'(va_trim >>> RW);

    ////////////////////////////////////////////////////////////////////////////
    // Apparent energy accumulators
    logic signed [raec_pkg::ACC_W-1:0] vacc_q;
    logic signed [raec_pkg::ACC_W-1:0] vrc_q;
    logic [raec_pkg::ACC_W-1:0] div_eff;
    logic [raec_pkg::ACC_W-1:0] quo_main;
    logic [raec_pkg::ACC_W-1:0] quo_rc;

    // Free-running signed sum; wraps silently past 48 bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            vacc_q <= '0;
        end else if (smp_en) begin
            vacc_q <= vacc_q + va_sample;
        end
    end

    // Read-to-clear twin; a sample landing with the read is kept, not lost
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            vrc_q <= '0;
        end else if (read_clear_rd) begin
            vrc_q <= smp_en ? va_sample : '0;
        end else if (smp_en) begin
            vrc_q <= vrc_q + va_sample;
        end
    end

    // Divisor zero behaves as one; a combinational divider trades area for latency
    assign div_eff = (cfg.apparent_divisor == '0) ? raec_pkg::ACC_W'(1) : raec_pkg::ACC_W'(cfg.apparent_divisor);
    assign quo_main = vacc_q / div_eff;
    assign quo_rc = vrc_q / div_eff;

    // Visible registers take the quotient's upper bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            apparent_energy_value <= '0;
            apparent_energy_read_clear <= '0;
        end else begin
            apparent_energy_value <= quo_main[raec_pkg::ACC_W-1:raec_pkg::EREG_LSB];
            apparent_energy_read_clear <= quo_rc[raec_pkg::ACC_W-1:raec_pkg::EREG_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Apparent energy events
    logic msb_prev_q;
    logic va_half_evt;
    logic va_ovf_evt;
    logic [raec_pkg::ST_W-1:0] evt;

    // Previous top bit; resets to the register's own reset level, so no false edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            msb_prev_q <= 1'b0;
        end else begin
            msb_prev_q <= apparent_energy_value[raec_pkg::EREG_W-1];
        end
    end

    // Unsigned register: half full when bit 23 rises, overflow when it drops
    assign va_half_evt = apparent_energy_value[raec_pkg::EREG_W-1] && !msb_prev_q;
    assign va_ovf_evt = !apparent_energy_value[raec_pkg::EREG_W-1] && msb_prev_q;

    // Event word in status bit order
    always_comb begin
        evt = '0;
        evt[raec_pkg::ST_CYC_END] = period_done;
        evt[raec_pkg::ST_VA_HALF] = va_half_evt;
        evt[raec_pkg::ST_VA_OVF] = va_ovf_evt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and interrupt pin
    logic [raec_pkg::ST_W-1:0] st_d;

    // Next flag word; a new event in the reading cycle wins over the clear
    always_comb begin
        st_d = irq_status | evt;
        if (status_rd) begin
            st_d = evt;
        end
    end

    // Sticky flags, cleared only by a status read
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_status <= raec_pkg::ST_RESET;
        end else begin
            irq_status <= st_d;
        end
    end

    // Pin follows the next flag word, so it never lags or outlives its flag
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_pin_oe <= 1'b0;
        end else begin
            irq_pin_oe <= |(st_d & cfg.irq_mask);
        end
    end
    // Open-drain: level is always low, only the enable moves
    assign irq_pin_out = 1'b0;

endmodule

// >>> test/raec_core_properties.sv
`timescale 1ns/1ps
// Port-level checks of the energy datapath
module raec_core_properties #(
    parameter int unsigned SW = 16,
    parameter int unsigned RW = 24,
    parameter int unsigned QW = 48
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Samples, configuration and strobes
    input wire logic signed [SW-1:0] cur_sample,
    input wire logic signed [SW-1:0] volt_sample,
    input wire logic [RW-1:0] cur_rms,
    input wire logic [RW-1:0] volt_rms,
    input wire logic volt_zero_cross,
    input wire raec_pkg::raec_cfg_s cfg,
    input wire logic read_clear_rd,
    input wire logic status_rd,
    // Results and interrupt pin
    input wire logic signed [2*SW-1:0] reactive_power,
    input wire logic signed [QW-1:0] line_reactive_energy,
    input wire logic [raec_pkg::EREG_W-1:0] apparent_energy_value,
    input wire logic [raec_pkg::EREG_W-1:0] apparent_energy_read_clear,
    input wire logic [raec_pkg::ST_W-1:0] irq_status,
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pin and cycle-end flag
    property p_pin_low;
        irq_pin_out == 1'b0;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("irq pin level not low");
    property p_oe_rise;
        $rose(irq_status[0]) && cfg.irq_mask[0] |-> irq_pin_oe;
    endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("unmasked flag without pin");
    property p_oe_cause;
        irq_pin_oe |-> (irq_status != 3'h0);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("pin active with no flag");
    property p_flag_cause;
        $rose(irq_status[0]) |-> $past(volt_zero_cross);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("cycle end off a crossing");
    property p_flag_clear;
        status_rd && !volt_zero_cross && !$past(volt_zero_cross) |=> !irq_status[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag kept after status read");
    ////////////////////////////////////////////////////////////////////////////
    // Datapath cadence, latching, clearing and the half-full flag
    property p_rp_cadence;
        $changed(reactive_power) |-> ##1 $stable(reactive_power) [*3];
    endproperty
    a_rp_cadence: assert property (p_rp_cadence) else $error("power changed off cadence");
    property p_le_cause;
        $changed(line_reactive_energy) |-> $past(volt_zero_cross);
    endproperty
    a_le_cause: assert property (p_le_cause) else $error("line energy latched off crossing");
    property p_rc_clear;
        read_clear_rd |-> ##2 (apparent_energy_read_clear < 24'h000002);
    endproperty
    a_rc_clear: assert property (p_rc_clear) else $error("read-clear copy not cleared");
    property p_half;
        $rose(apparent_energy_value[23]) |-> ##[0:2] irq_status[1];
    endproperty
    a_half: assert property (p_half) else $error("half full flag missing");
endmodule

bind raec_core raec_core_properties #(.SW(SW), .RW(RW), .QW(QW)) u_props (.core_clk, .rst, .cur_sample,
    .volt_sample, .cur_rms, .volt_rms, .volt_zero_cross, .cfg, .read_clear_rd, .status_rd, .reactive_power,
    .line_reactive_energy, .apparent_energy_value, .apparent_energy_read_clear, .irq_status, .irq_pin_out,
    .irq_pin_oe);

// >>> test/raec_host.sv
`timescale 1ns/1ps
// Host side: read strobes and the pulled-up interrupt line
module raec_host (
    // Clock
    input wire logic core_clk,
    // Interrupt pin from the device
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe,
    // Read strobes and resolved line
    output logic read_clear_rd,
    output logic status_rd,
    output logic irq_n
);
    // Open-drain line falls back to the pull-up when released
    assign irq_n = irq_pin_oe ? irq_pin_out : 1'b1;
    initial begin
        read_clear_rd = 1'b0;
        status_rd = 1'b0;
    end
    // One-cycle strobe, called at a falling edge, taken at the next rise
    task automatic strobe(input logic clr);
        read_clear_rd = clr;
        status_rd = ~clr;
        @(negedge core_clk);
        read_clear_rd = 1'b0;
        status_rd = 1'b0;
    endtask
endmodule

// >>> test/tb_reactive_apparent_energy_calc.sv
`timescale 1ns/1ps
module tb_reactive_apparent_energy_calc;
    logic core_clk, rst, volt_zero_cross, read_clear_rd, status_rd, irq_n, irq_pin_out, irq_pin_oe;
    logic signed [15:0] cur_sample, volt_sample;
    logic [23:0] cur_rms, volt_rms, apparent_energy_value, apparent_energy_read_clear;
    raec_pkg::raec_cfg_s cfg;
    logic signed [31:0] reactive_power;
    logic signed [47:0] line_reactive_energy;
    logic [2:0] irq_status;
    int error_cnt, n_checks;
    ////////////////////////////////////////////////////////////////////////////
    raec_core dut (.core_clk, .rst, .cur_sample, .volt_sample, .cur_rms, .volt_rms, .volt_zero_cross, .cfg,
        .read_clear_rd, .status_rd, .reactive_power, .line_reactive_energy, .apparent_energy_value,
        .apparent_energy_read_clear, .irq_status, .irq_pin_out, .irq_pin_oe);
    raec_host host (.core_clk, .irq_pin_out, .irq_pin_oe, .read_clear_rd, .status_rd, .irq_n);
    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Reset also restarts the sample divider, so edge counts below are exact
    task automatic do_reset;
        @(negedge core_clk);
        rst = 1'b1;
        repeat (16) @(negedge core_clk);
        rst = 1'b0;
        check(irq_status, 3'h0);
        check(irq_pin_oe, 1'b0);
    endtask
    // Rms inputs of 2^23 give a word of 1024*(4096+gain) per sample
    task automatic run_va(input logic [11:0] g, input logic [7:0] d);
        longint w;
        longint dq;
        cfg.apparent_gain = g;
        cfg.apparent_divisor = d;
        dq = (d == 8'h00) ? 1 : longint'(d);
        w = 1024 * (4096 + longint'($signed(g)));
        do_reset();
        repeat (258) @(negedge core_clk);
        check(apparent_energy_value, ((w * 64) / dq) >> 24);
        check(apparent_energy_read_clear, ((w * 64) / dq) >> 24);
        host.strobe(1'b1);
        @(negedge core_clk);
        check(apparent_energy_read_clear, 64'h0);
        repeat (256) @(negedge core_clk);
        check(apparent_energy_read_clear, ((w * 64) / dq) >> 24);
        check(apparent_energy_value, ((w * 128) / dq) >> 24);
    endtask
    // Three half cycles: opening crossing plus three more closes the period
    // Steady current: the sign of the result follows the shift direction
    task automatic run_line(input logic m);
        cfg.irq_mask = {2'h0, m};
        cfg.integrator_en = m;
        cfg.half_cycle_count = 16'h0003;
        cfg.line_accumulation_select = 1'b1;
        cur_sample = 16'sh1000;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            repeat (37) @(negedge core_clk);
            check(irq_status[0], 1'b0);
            volt_zero_cross = 1'b1;
            @(negedge core_clk);
            volt_zero_cross = 1'b0;
        end
        repeat (2) @(negedge core_clk);
        check(irq_status[0], 1'b1);
        check(irq_n, !m);
        check(line_reactive_energy[47], !m);
        check(line_reactive_energy != 48'h0, 1'b1);
        check(reactive_power[31], !m);
        check(reactive_power != 32'h0, 1'b1);
        host.strobe(1'b0);
        check(irq_status[0], 1'b0);
        check(irq_pin_oe, 1'b0);
        cfg.line_accumulation_select = 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst = 1'b1;
        volt_zero_cross = 1'b0;
        cur_sample = 16'sh0000;
        volt_sample = 16'sh1000;
        cur_rms = 24'h800000;
        volt_rms = 24'h800000;
        cfg = '0;
        error_cnt = 0;
        n_checks = 0;
        run_va(12'h000, 8'h00);
        run_va(12'h000, 8'h01);
        run_va(12'h000, 8'h03);
        run_va(12'h7ff, 8'h00);
        run_va(12'h800, 8'h02);
        run_line(1'b1);
        run_line(1'b0);
        give_verdict();
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #40000;
        error_cnt++;
        give_verdict();
    end
endmodule
